//--- dv/flash_host_model.sv
// host serial controller model: frames commands and reads answers on the link
module flash_host_model (
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic      [3:0] io_out,
  input  wire logic [3:0] io_in,
  input  wire logic [3:0] io_oe_n_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // deselect rises after time zero so the link side sees a real edge
  initial begin
    sclk_out = 1'b0;
    io_out   = 4'h5;
    #1 cs_n_out = 1'b1;
  end

  // nclk units out msb first, then nrd units in; sclk stands low outside frames
  task automatic frame(input logic [39:0] data, input int nclk, input logic quad,
                       input int nrd, output logic [7:0] rd, output logic drv);
    logic [39:0] sh;
    sh = data;
    rd = 8'h00;
    drv = 1'b0;
    cs_n_out = 1'b0;
    for (int i = 0; i < nclk + nrd; i++) begin
      if (i < nclk) begin
        io_out = quad ? sh[39:36] : {~io_out[3:1], sh[39]};
        sh = quad ? sh << 4 : sh << 1;
      end else begin
        io_out = ~io_out;
      end
      #62.5 sclk_out = 1'b1;
      if (i >= nclk) begin
        rd = quad ? {rd[3:0], io_in} : {rd[6:0], io_in[1]};
        drv = drv | (io_oe_n_in != 4'hf);
      end
      #62.5 sclk_out = 1'b0;
    end
    #62.5 cs_n_out = 1'b1;
    io_out = ~io_out;
  endtask
endmodule // flash_host_model

//--- dv/flash_protect_suspend_ctrl_tb_top.sv
// testbench: protect, security and suspend command checks over the serial link
module flash_protect_suspend_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LIMIT = 40000;
  logic                       mclk, srst, sclk, cs_n, quad, perf, e_act, p_act;
  logic                       sel_nv, otp_nv, fac_nv, wlf, otp_ok, s_req, r_req, drv;
  logic [3:0]                 host_io, dev_io, oe_n, io_wire;
  logic [23:0]                act_adr;
  logic [7:0]                 sec, rd;
  flash_prot_pkg::array_cmd_t acmd, last_cmd;
  int                         n_mismatch, cmp_count, n_susp, n_res, n_fwd, cycles;

  assign io_wire = (~oe_n & dev_io) | (oe_n & host_io);

  flash_protect_suspend_ctrl u_flash_protect_suspend_ctrl (
    .mclk_in(mclk), .srst_in(srst), .sclk_in(sclk), .cs_n_in(cs_n), .io_in(io_wire),
    .io_out(dev_io), .io_oe_n_out(oe_n), .quad_command_mode_in(quad),
    .perf_enhance_in(perf), .erase_active_in(e_act), .program_active_in(p_act),
    .active_addr_in(act_adr), .select_nv_in(sel_nv), .otp_lock_nv_in(otp_nv),
    .factory_lock_nv_in(fac_nv), .security_reg_out(sec), .write_latch_flag_out(wlf),
    .otp_write_ok_out(otp_ok), .suspend_req_out(s_req), .resume_req_out(r_req),
    .array_cmd_out(acmd)
  );

  flash_host_model u_flash_host_model (
    .sclk_out(sclk), .cs_n_out(cs_n), .io_out(host_io), .io_in(io_wire), .io_oe_n_in(oe_n)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (srst === 1'b0) begin
      if (s_req === 1'b1) n_susp++;
      if (r_req === 1'b1) n_res++;
      if (acmd.valid === 1'b1) begin
        n_fwd++;
        last_cmd = acmd;
      end
    end
    if (cycles == LIMIT) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset();
    @(negedge mclk) srst = 1'b1;
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
  endtask

  // one command frame; extra clocks break the byte boundary
  task automatic run(input logic [7:0] op, input logic [23:0] adr, input bit with_adr,
                     input int extra);
    int n;
    n = (with_adr ? 32 : 8) / (quad ? 4 : 1) + extra;
    u_flash_host_model.frame({op, adr, 8'h00}, n, quad,
                             (op == flash_prot_pkg::OP_LOCK_QUERY) ? (quad ? 2 : 8) : 0, rd, drv);
    repeat (12) @(negedge mclk);
  endtask

  task automatic wl();
    run(flash_prot_pkg::OP_WRITE_LATCH_SET, 24'h000000, 0, 0);
  endtask

  // query lock state of one unit, expecting a driven byte
  task automatic query(input logic [23:0] adr, input logic [7:0] exp);
    run(flash_prot_pkg::OP_LOCK_QUERY, adr, 1, 0);
    check("query_driven", drv, 1'b1);
    check("query_byte", rd, exp);
  endtask

  // mode change, then a short refused frame so the link side sees it
  task automatic set_quad(input logic q);
    @(negedge mclk) quad = q;
    u_flash_host_model.frame(40'h0000000000, 3, q, 0, rd, drv);
    repeat (12) @(negedge mclk);
  endtask

  // low at start: do_reset raises it, so the async toggle clear sees an edge
  initial begin
    srst = 1'b0;
    quad = 1'b0;
    perf = 1'b0;
    e_act = 1'b0;
    p_act = 1'b0;
    act_adr = 24'h000000;
    sel_nv = 1'b0;
    otp_nv = 1'b0;
    fac_nv = 1'b1;
    do_reset();
    check("security_reg_reset", sec, 8'h01);
    check("otp_write_ok_reset", otp_ok, 1'b1);
    run(flash_prot_pkg::OP_SECURITY_WRITE, 24'h000000, 0, 0);
    check("otp_lock_no_latch", sec[1], 1'b0);
    wl();
    check("write_latch", wlf, 1'b1);
    run(flash_prot_pkg::OP_SECURITY_WRITE, 24'h000000, 0, 1);
    check("otp_lock_bad_boundary", sec[1], 1'b0);
    run(flash_prot_pkg::OP_SECURITY_WRITE, 24'h000000, 0, 0);
    check("otp_lock_set", sec, 8'h03);
    check("otp_write_ok_locked", otp_ok, 1'b0);
    check("latch_consumed", wlf, 1'b0);
    run(flash_prot_pkg::OP_LOCK_QUERY, 24'h050000, 1, 0);
    check("query_before_select", drv, 1'b0);
    set_quad(1'b1);
    wl();
    run(flash_prot_pkg::OP_PROTECT_SELECT, 24'h000000, 0, 0);
    check("select_quad", sec, 8'h83);
    set_quad(1'b0);
    sel_nv = 1'b1;
    otp_nv = 1'b1;
    do_reset();
    check("select_after_boot", sec, 8'h83);
    query(24'h050000, 8'hff);
    wl();
    run(flash_prot_pkg::OP_PAGE_PROGRAM, 24'h050000, 1, 0);
    check("program_locked_refused", n_fwd, 0);
    wl();
    run(flash_prot_pkg::OP_GLOBAL_UNLOCK, 24'h000000, 0, 0);
    query(24'h050000, 8'h00);
    wl();
    run(flash_prot_pkg::OP_GLOBAL_LOCK, 24'h000000, 0, 0);
    query(24'h0f0000, 8'hff);
    run(flash_prot_pkg::OP_GLOBAL_UNLOCK, 24'h000000, 0, 0);
    query(24'h0f0000, 8'hff);
    wl();
    run(flash_prot_pkg::OP_GLOBAL_UNLOCK, 24'h000000, 0, 1);
    query(24'h0f0000, 8'hff);
    wl();
    run(flash_prot_pkg::OP_GLOBAL_UNLOCK, 24'h000000, 0, 0);
    wl();
    run(flash_prot_pkg::OP_SINGLE_LOCK, 24'h031000, 1, 0);
    query(24'h030000, 8'hff);
    query(24'h040000, 8'h00);
    wl();
    run(flash_prot_pkg::OP_SINGLE_LOCK, 24'h002000, 1, 0);
    query(24'h003000, 8'h00);
    set_quad(1'b1);
    query(24'h002000, 8'hff);
    set_quad(1'b0);
    wl();
    run(flash_prot_pkg::OP_SINGLE_UNLOCK, 24'h002000, 1, 0);
    query(24'h002000, 8'h00);
    wl();
    run(flash_prot_pkg::OP_PAGE_PROGRAM, 24'h040100, 1, 0);
    check("program_forwarded", last_cmd, {1'b1, 8'h02, 24'h040100});
    @(negedge mclk) e_act = 1'b1;
    act_adr = 24'h010000;
    wl();
    run(flash_prot_pkg::OP_SUSPEND, 24'h000000, 0, 0);
    check("erase_held", sec[3:2], 2'b10);
    check("latch_cleared_erase_hold", wlf, 1'b0);
    check("suspend_pulses", n_susp, 1);
    repeat (2000) @(negedge mclk);
    wl();
    check("latch_refused_erase_hold", wlf, 1'b0);
    perf = 1'b1;
    run(flash_prot_pkg::OP_RESUME, 24'h000000, 0, 0);
    check("resume_in_perf_mode", {sec[3], 8'(n_res)}, {1'b1, 8'h00});
    perf = 1'b0;
    run(flash_prot_pkg::OP_RESUME, 24'h000000, 0, 0);
    check("erase_resumed", {sec[3], 8'(n_res)}, {1'b0, 8'h01});
    @(negedge mclk) e_act = 1'b0;
    p_act = 1'b1;
    repeat (2000) @(negedge mclk);
    set_quad(1'b1);
    run(flash_prot_pkg::OP_SUSPEND, 24'h000000, 0, 0);
    check("program_held", {sec[3:2], 8'(n_susp)}, {2'b01, 8'h02});
    repeat (2000) @(negedge mclk);
    wl();
    check("latch_refused_prog_hold", wlf, 1'b0);
    run(flash_prot_pkg::OP_RESUME, 24'h000000, 0, 0);
    check("program_resumed", {sec[2], 8'(n_res)}, {1'b0, 8'h02});
    wl();
    check("latch_after_resume", wlf, 1'b1);
    run(flash_prot_pkg::OP_SECTOR_ERASE, 24'h041000, 1, 0);
    check("erase_forwarded", last_cmd, {1'b1, flash_prot_pkg::OP_SECTOR_ERASE, 24'h041000});
    check("latch_consumed_erase", wlf, 1'b0);
    wrap_up();
  end
endmodule // flash_protect_suspend_ctrl_tb_top

//--- hdl/flash_protect_suspend_ctrl.sv
// block protection, security register and suspend/resume command logic
// What this block does
// - security write needs latch, only sets bit1
// - otp lock flag sticky, refuses otp updates
// - write protect commands need exact byte boundary
// - eight single or two quad opcode clocks
// - protect select sets bit7 for good
// - per-block mode boots with everything locked
// - lock commands ignored before protect select
// - 36h/39h plus address lock or unlock one unit
// - 3Ch query returns lock state byte
// - 7Eh/98h lock or unlock whole chip
// - B0h suspends, 30h resumes array work
// - bit3 erase held, bit2 program held
// - erase hold clears latch, limits opcodes
// - erase hold: 06h refused, so no program in either bank
// - program hold clears latch, read-only opcodes
// - resume needs no latch, clears held flag
// - resume ignored in performance enhance mode
module flash_protect_suspend_ctrl (
  input  wire logic                     mclk_in,
  input  wire logic                     srst_in,
  input  wire logic                     sclk_in,
  input  wire logic                     cs_n_in,
  input  wire logic [3:0]               io_in,
  output logic      [3:0]               io_out,
  output logic      [3:0]               io_oe_n_out,
  input  wire logic                     quad_command_mode_in,
  input  wire logic                     perf_enhance_in,
  input  wire logic                     erase_active_in,
  input  wire logic                     program_active_in,
  input  wire logic [23:0]              active_addr_in,
  input  wire logic                     select_nv_in,
  input  wire logic                     otp_lock_nv_in,
  input  wire logic                     factory_lock_nv_in,
  output logic      [7:0]               security_reg_out,
  output logic                          write_latch_flag_out,
  output logic                          otp_write_ok_out,
  output logic                          suspend_req_out,
  output logic                          resume_req_out,
  output flash_prot_pkg::array_cmd_t    array_cmd_out
);
  // ---------------- link side, on the serial clock ----------------
  logic                                 first;
  logic                                 frame_tgl;
  logic [31:0]                          sh;
  logic [31:0]                          next_sh;
  logic [7:0]                           op_k;
  logic [5:0]                           nbits;
  logic [5:0]                           nb_base;
  logic [5:0]                           next_nb;
  logic                                 quad_k;
  logic                                 select_k;
  logic [flash_prot_pkg::LOCK_N-1:0]    locks_k;
  logic [flash_prot_pkg::LOCK_N-1:0]    locks;
  logic                                 select;
  logic                                 query_bit;

  sync2 #(.W(flash_prot_pkg::LOCK_N + 2)) u_sync_link (
    .clk_in (sclk_in),
    .d_in   ({quad_command_mode_in, select, locks}),
    .q_out  ({quad_k, select_k, locks_k})
  );

  // set while deselected, so the first clock of a frame restarts capture
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      first <= 1'b1;
    end else begin
      first <= 1'b0;
    end
  end

  always_ff @(posedge sclk_in or posedge srst_in) begin
    if (srst_in) begin
      frame_tgl <= 1'b0;
    end else if (first) begin
      frame_tgl <= ~frame_tgl;
    end
  end

  always_comb begin
    nb_base = first ? '0 : nbits;
    next_sh = first ? '0 : sh;
    next_nb = nb_base;
    if (nb_base < flash_prot_pkg::NB_MAX) begin
      if (quad_k) begin
        next_sh = {next_sh[27:0], io_in};
        next_nb = nb_base + flash_prot_pkg::STEP_QUAD;
      end else begin
        next_sh = {next_sh[30:0], io_in[0]};
        next_nb = nb_base + flash_prot_pkg::STEP_ONE;
      end
    end
  end

  // no reset: contents must survive the rise of chip select
  always_ff @(posedge sclk_in) begin
    nbits <= next_nb;
    if (nb_base < flash_prot_pkg::NB_ADDR) begin
      sh <= next_sh;
    end
    if (next_nb == flash_prot_pkg::NB_OP) begin
      op_k <= next_sh[7:0];
    end
  end

  assign query_bit = locks_k[flash_prot_pkg::lock_index(sh[23:0])];

  // lock state byte after opcode and address, repeated while clocked
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      io_oe_n_out <= 4'hf;
      io_out <= 4'h0;
    end else if (nbits >= flash_prot_pkg::NB_ADDR && select_k &&
                 op_k == flash_prot_pkg::OP_LOCK_QUERY) begin
      io_oe_n_out <= quad_k ? 4'h0 : 4'hd;
      io_out <= {4{query_bit}};
    end
  end

  // ---------------- control side, on the main clock ----------------
  logic                                 cs_s;
  logic                                 tgl_s;
  logic                                 seen;
  logic                                 go;
  logic                                 boot;
  flash_prot_pkg::frame_t               f;
  logic                                 len8;
  logic                                 len32;
  logic                                 allowed;
  logic                                 x;
  logic                                 write_latch_flag;
  logic                                 otp_lock;
  logic                                 factory;
  logic                                 erase_held;
  logic                                 prog_held;
  logic                                 held_bank;
  logic                                 is_prog;
  logic                                 is_erase;
  logic                                 target_locked;
  logic                                 do_write_latch_set_cmd;
  logic                                 do_scur;
  logic                                 do_sel;
  logic                                 do_lock1;
  logic                                 do_unlock1;
  logic                                 do_glock;
  logic                                 do_gunlock;
  logic                                 do_susp;
  logic                                 do_res;
  logic                                 do_arr;

  sync2 #(.W(2)) u_sync_ctl (
    .clk_in (mclk_in),
    .d_in   ({cs_n_in, frame_tgl}),
    .q_out  ({cs_s, tgl_s})
  );

  // a frame is taken once chip select is back high; captured data is still
  assign go = cs_s && (tgl_s != seen);

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      seen <= 1'b0;
    end else if (go) begin
      seen <= tgl_s;
    end
  end

  always_comb begin
    f.op = op_k;
    f.adr = sh[23:0];
    f.nbits = nbits;
  end

  assign len8 = f.nbits == flash_prot_pkg::NB_OP;
  assign len32 = f.nbits == flash_prot_pkg::NB_ADDR;
  assign allowed = erase_held ? flash_prot_pkg::ok_in_erase_hold(f.op) :
                   prog_held ? flash_prot_pkg::ok_in_prog_hold(f.op) : 1'b1;
  assign x = go && allowed;
  assign is_prog = f.op == flash_prot_pkg::OP_PAGE_PROGRAM;
  assign is_erase = f.op == flash_prot_pkg::OP_SECTOR_ERASE ||
                    f.op == flash_prot_pkg::OP_BLOCK_ERASE;
  assign target_locked = select && locks[flash_prot_pkg::lock_index(f.adr)];

  assign do_write_latch_set_cmd = x && len8 && f.op == flash_prot_pkg::OP_WRITE_LATCH_SET;
  assign do_scur = x && len8 && write_latch_flag && !otp_lock &&
                   f.op == flash_prot_pkg::OP_SECURITY_WRITE;
  assign do_sel = x && len8 && write_latch_flag &&
                  f.op == flash_prot_pkg::OP_PROTECT_SELECT;
  assign do_lock1 = x && len32 && write_latch_flag && select &&
                    f.op == flash_prot_pkg::OP_SINGLE_LOCK;
  assign do_unlock1 = x && len32 && write_latch_flag && select &&
                      f.op == flash_prot_pkg::OP_SINGLE_UNLOCK;
  assign do_glock = x && len8 && write_latch_flag && select &&
                    f.op == flash_prot_pkg::OP_GLOBAL_LOCK;
  assign do_gunlock = x && len8 && write_latch_flag && select &&
                      f.op == flash_prot_pkg::OP_GLOBAL_UNLOCK;
  assign do_susp = x && len8 && f.op == flash_prot_pkg::OP_SUSPEND &&
                   !erase_held && !prog_held &&
                   (erase_active_in || program_active_in);
  assign do_res = x && len8 && f.op == flash_prot_pkg::OP_RESUME &&
                  (erase_held || prog_held) && !perf_enhance_in;
  assign do_arr = x && len32 && write_latch_flag && (is_prog || is_erase) && !target_locked &&
                  !(erase_held && (is_erase ||
                    f.adr[flash_prot_pkg::BANK_BIT] == held_bank));

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      boot <= 1'b1;
    end else begin
      boot <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      write_latch_flag <= 1'b0;
    end else if (do_write_latch_set_cmd) begin
      write_latch_flag <= 1'b1;
    end else if (do_scur || do_sel || do_lock1 || do_unlock1 || do_glock ||
                 do_gunlock || do_arr || do_susp) begin
      write_latch_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      otp_lock <= 1'b0;
      factory <= 1'b0;
    end else if (boot) begin
      otp_lock <= otp_lock_nv_in;
      factory <= factory_lock_nv_in;
    end else if (do_scur) begin
      otp_lock <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      select <= 1'b0;
    end else if (boot) begin
      select <= select_nv_in;
    end else if (do_sel) begin
      select <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      locks <= '0;
    end else if (boot) begin
      locks <= {flash_prot_pkg::LOCK_N{select_nv_in}};
    end else if (do_glock) begin
      locks <= '1;
    end else if (do_gunlock) begin
      locks <= '0;
    end else if (do_lock1) begin
      locks[flash_prot_pkg::lock_index(f.adr)] <= 1'b1;
    end else if (do_unlock1) begin
      locks[flash_prot_pkg::lock_index(f.adr)] <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      erase_held <= 1'b0;
      prog_held <= 1'b0;
      held_bank <= 1'b0;
    end else if (do_susp) begin
      erase_held <= erase_active_in;
      prog_held <= !erase_active_in;
      held_bank <= active_addr_in[flash_prot_pkg::BANK_BIT];
    end else if (do_res) begin
      erase_held <= 1'b0;
      prog_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      suspend_req_out <= 1'b0;
      resume_req_out <= 1'b0;
      array_cmd_out <= '0;
    end else begin
      suspend_req_out <= do_susp;
      resume_req_out <= do_res;
      array_cmd_out.valid <= do_arr;
      if (do_arr) begin
        array_cmd_out.op <= f.op;
        array_cmd_out.adr <= f.adr;
      end
    end
  end

  always_comb begin
    security_reg_out = '0;
    security_reg_out[flash_prot_pkg::SR_FACTORY] = factory;
    security_reg_out[flash_prot_pkg::SR_OTP_LOCK] = otp_lock;
    security_reg_out[flash_prot_pkg::SR_PROG_HELD] = prog_held;
    security_reg_out[flash_prot_pkg::SR_ERASE_HELD] = erase_held;
    security_reg_out[flash_prot_pkg::SR_SELECT] = select;
  end

  assign write_latch_flag_out = write_latch_flag;
  assign otp_write_ok_out = !otp_lock;

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  sequence s_erase_susp;
    do_susp && erase_active_in;
  endsequence

  sequence s_erase_held_now;
    erase_held && !prog_held && !write_latch_flag;
  endsequence

  property p_otp_sticky;
    otp_lock && !boot |=> otp_lock;
  endproperty
  a_otp_sticky: assert property (p_otp_sticky)
    else $error("otp lock flag dropped");

  property p_sel_sticky;
    select && !boot |=> select;
  endproperty
  a_sel_sticky: assert property (p_sel_sticky)
    else $error("protect select dropped");

  property p_no_latch;
    go && !write_latch_flag && f.op != flash_prot_pkg::OP_WRITE_LATCH_SET
      |=> $stable(locks) && $stable(otp_lock) && $stable(select);
  endproperty
  a_no_latch: assert property (p_no_latch)
    else $error("protect state changed without latch");

  property p_boundary;
    go && !len8 && !len32 |=> $stable(locks) && $stable(otp_lock) && $stable(select);
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("misaligned frame executed");

  property p_pre_select;
    go && !select |=> $stable(locks);
  endproperty
  a_pre_select: assert property (p_pre_select)
    else $error("locks changed before protect select");

  property p_erase_susp;
    s_erase_susp |=> s_erase_held_now ##0 suspend_req_out;
  endproperty
  a_erase_susp: assert property (p_erase_susp)
    else $error("erase suspend flags wrong");

  property p_resume;
    do_res |=> !erase_held && !prog_held ##0 resume_req_out ##1 !resume_req_out;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not clear held flags");

  property p_perf;
    go && perf_enhance_in && (erase_held || prog_held) |=> $stable(erase_held)
      && $stable(prog_held) && !resume_req_out;
  endproperty
  a_perf: assert property (p_perf)
    else $error("resume taken in enhance mode");

  property p_bank;
    array_cmd_out.valid && erase_held
      |-> array_cmd_out.op == flash_prot_pkg::OP_PAGE_PROGRAM &&
          array_cmd_out.adr[flash_prot_pkg::BANK_BIT] != held_bank;
  endproperty
  a_bank: assert property (p_bank)
    else $error("program in held bank");

  property p_prog_hold;
    prog_held |-> !array_cmd_out.valid && !write_latch_flag;
  endproperty
  a_prog_hold: assert property (p_prog_hold)
    else $error("write accepted during program hold");

  property p_gang;
    do_glock |=> &locks;
  endproperty
  a_gang: assert property (p_gang)
    else $error("global lock incomplete");
endmodule // flash_protect_suspend_ctrl

//--- hdl/sync2.sv
// two-flop level synchroniser
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_in) begin
    meta <= d_in;
    q_out <= meta;
  end
endmodule // sync2

//--- include/flash_prot_pkg.sv
// package: opcodes, field positions, sizes and carrier types of the protect/suspend logic
package flash_prot_pkg;
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_SECURITY_WRITE  = 8'h2f;
  localparam logic [7:0] OP_PROTECT_SELECT  = 8'h6a;
  localparam logic [7:0] OP_SINGLE_LOCK     = 8'h36;
  localparam logic [7:0] OP_SINGLE_UNLOCK   = 8'h39;
  localparam logic [7:0] OP_LOCK_QUERY      = 8'h3c;
  localparam logic [7:0] OP_GLOBAL_LOCK     = 8'h7e;
  localparam logic [7:0] OP_GLOBAL_UNLOCK   = 8'h98;
  localparam logic [7:0] OP_SUSPEND         = 8'hb0;
  localparam logic [7:0] OP_RESUME          = 8'h30;
  localparam logic [7:0] OP_PAGE_PROGRAM    = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE    = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE     = 8'hd8;

  localparam logic [5:0] NB_OP    = 6'd8;
  localparam logic [5:0] NB_ADDR  = 6'd32;
  localparam logic [5:0] NB_MAX   = 6'd40;
  localparam logic [5:0] STEP_ONE = 6'd1;
  localparam logic [5:0] STEP_QUAD = 6'd4;

  localparam int SR_FACTORY = 0;
  localparam int SR_OTP_LOCK = 1;
  localparam int SR_PROG_HELD = 2;
  localparam int SR_ERASE_HELD = 3;
  localparam int SR_SELECT = 7;

  localparam int BLOCKS = 16;
  localparam int SECTS = 16;
  localparam int LOCK_N = BLOCKS + 2 * SECTS;
  localparam int BANK_BIT = 19;
  localparam logic [3:0] BLK_FIRST = 4'h0;
  localparam logic [3:0] BLK_LAST = 4'hf;

  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] adr;
    logic [5:0]  nbits;
  } frame_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  op;
    logic [23:0] adr;
  } array_cmd_t;

  // first and last block are locked per 4K sector, the rest per 64K block
  function automatic logic [5:0] lock_index(input logic [23:0] a);
    if (a[19:16] == BLK_FIRST) return 6'(BLOCKS) + 6'(a[15:12]);
    if (a[19:16] == BLK_LAST) return 6'(BLOCKS + SECTS) + 6'(a[15:12]);
    return 6'(a[19:16]);
  endfunction

  function automatic logic ok_in_erase_hold(input logic [7:0] op);
    case (op)
      8'h03, 8'h0b, 8'hbb, 8'heb, 8'he7, 8'h9f, 8'haf, 8'h90, 8'h05, 8'h2b,
      8'hb1, 8'hc1, 8'h5a, 8'h02, 8'h38, 8'h3c, 8'h30, 8'h66, 8'h99, 8'hc0,
      8'h35, 8'hf5, 8'h00, 8'hab: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic ok_in_prog_hold(input logic [7:0] op);
    return ok_in_erase_hold(op) && op != 8'h02 && op != 8'h38;
  endfunction
endpackage
